// ==== core/iet_pkg.sv ====
// constants for the infrared carrier envelope timer.
// assumes one 250 MHz clock and a 32-bit classic wishbone slave port.
package iet_pkg;

   // clock and timing
   localparam int unsigned CLK_FREQ_MHZ   = 250;
   localparam int unsigned TICK_DIV       = 64;
   localparam int unsigned STAB_TIME_NS   = 1000;
   localparam int unsigned STAB_CYCLES    = (STAB_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned PRESC_W        = 6;
   localparam int unsigned STAB_W         = 9;
   localparam int unsigned CNT_W          = 9;

   localparam logic [PRESC_W-1:0] PRESC_LAST  = 6'(TICK_DIV - 1);
   localparam logic [STAB_W-1:0]  STAB_LOAD   = 9'(STAB_CYCLES);

   // register byte addresses
   localparam int unsigned        ADR_W             = 8;
   localparam logic [ADR_W-1:0]   ADDR_COUNT_LOW    = 8'h00;
   localparam logic [ADR_W-1:0]   ADDR_CONTROL      = 8'h04;
   localparam logic [ADR_W-1:0]   ADDR_STATUS       = 8'h08;

   // control register fields
   localparam int unsigned CTL_BIT8_POS   = 0;
   localparam int unsigned CTL_RUN_POS    = 1;
   localparam int unsigned CTL_NRDY_POS   = 5;
   localparam int unsigned CTL_FUNC_POS   = 6;
   localparam int unsigned CTL_END_POS    = 7;

   // status register fields
   localparam int unsigned STS_GATE_POS   = 0;
   localparam int unsigned STS_ZERO_POS   = 1;
   localparam int unsigned STS_CNT_POS    = 16;

   // reset values
   localparam logic [7:0]       COUNT_LOW_RST = 8'h00;
   localparam logic [CNT_W-1:0] COUNTER_RST   = 9'h000;
   localparam logic [CNT_W-1:0] COUNTER_ONE   = 9'h001;
   localparam logic             FUNC_RST      = 1'b0;
   localparam logic             END_RST       = 1'b1;
   localparam logic [31:0]      DATA_ZERO     = 32'h0000_0000;

   // output function select encodings
   localparam logic FUNC_OPEN_DRAIN = 1'b0;
   localparam logic FUNC_PUSH_PULL  = 1'b1;

endpackage : iet_pkg

// ==== core/iet_envelope_timer.sv ====
// envelope timer gating the ir carrier onto the dual-function output pin.
// assumes carrier, carrier disable and halt come from logic on REF_CLK;
// software reaches the registers over a 32-bit classic wishbone slave.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps

module iet_envelope_timer (
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   input  wire logic                        CYC_I,
   input  wire logic                        STB_I,
   input  wire logic                        WE_I,
   input  wire logic [iet_pkg::ADR_W-1:0]   ADR_I,
   input  wire logic [3:0]                  SEL_I,
   input  wire logic [31:0]                 DAT_I,
   output logic      [31:0]                 DAT_O,
   output logic                             ACK_O,
   input  wire logic                        CARRIER_IN,
   input  wire logic                        CARRIER_DISABLE,
   input  wire logic                        HALT_ACTIVE,
   output logic                             CARRIER_RESTART,
   output logic                             TIMER_GATE,
   output logic                             TIMER_END,
   output logic                             EMIT_O,
   output logic                             EMIT_OE
);

   // register file state
   logic [7:0]                     count_low_byte_reg;
   logic                           count_bit_eight_reg;
   logic                           run_enable_reg;
   logic                           func_sel_reg;
   logic                           operation_end_flag_reg;
   logic                           driver_not_ready_reg;

   // timer state
   logic [iet_pkg::CNT_W-1:0]      counter_reg;
   logic [iet_pkg::PRESC_W-1:0]    presc_reg;
   logic [iet_pkg::STAB_W-1:0]     stab_reg;
   logic                           halt_prev_reg;

   // bus decode
   logic                           bus_req;
   logic                           wr_low;
   logic                           wr_ctl;
   logic                           wr_run;
   logic                           wr_func;
   logic                           wr_bit8;
   logic                           counting;
   logic                           load_ctl;
   logic                           tick;
   logic                           run_rise;
   logic                           od_entry;
   logic                           counter_zero;
   logic                           driver_not_ready;
   logic                           gated_signal;
   logic [iet_pkg::CNT_W-1:0]      load_value;
   logic [31:0]                    rd_next;
   logic                           wr_req;
   logic                           rd_req;
   logic                           end_tick;
   logic                           step;
   logic                           func_switch;
   logic                           halt_wake;
   logic [7:0]                     ctl_rd;
   logic [31:0]                    sts_rd;

   // single-cycle classic request; ack drops the cycle after it rises
   assign bus_req  = CYC_I & STB_I & ~ACK_O;
   assign wr_req   = bus_req & WE_I & SEL_I[0];
   assign wr_low   = wr_req & (ADR_I == iet_pkg::ADDR_COUNT_LOW);
   assign wr_ctl   = wr_req & (ADR_I == iet_pkg::ADDR_CONTROL);
   assign wr_run   = DAT_I[iet_pkg::CTL_RUN_POS];
   assign wr_func  = DAT_I[iet_pkg::CTL_FUNC_POS];
   assign wr_bit8  = DAT_I[iet_pkg::CTL_BIT8_POS];

   // counting only while enabled and not yet ended
   assign counting = run_enable_reg & ~operation_end_flag_reg;

   // a control write while the count is live only stores fields, so a
   // read-modify-write that clears run keeps the count value
   assign load_ctl   = wr_ctl & ~counting;
   assign load_value = {wr_bit8, count_low_byte_reg};

   assign tick       = (presc_reg == iet_pkg::PRESC_LAST);
   assign counter_zero = (counter_reg == iet_pkg::COUNTER_RST);

   // the last tick of a live count ends the operation
   assign end_tick = counting & tick & counter_zero;
   assign step     = counting & tick & ~counter_zero;
   assign rd_req   = bus_req & ~WE_I;

   // run rises when written 1 over a stored 0
   assign run_rise = wr_ctl & wr_run & ~run_enable_reg;

   // driver becomes active: leaving halt or switching from push-pull
   assign func_switch = wr_ctl & (wr_func == iet_pkg::FUNC_OPEN_DRAIN)
                      & (func_sel_reg == iet_pkg::FUNC_PUSH_PULL);
   assign halt_wake   = halt_prev_reg & ~HALT_ACTIVE
                      & (func_sel_reg == iet_pkg::FUNC_OPEN_DRAIN);
   assign od_entry    = func_switch | halt_wake;

   // flag has no meaning in push-pull mode
   assign driver_not_ready = driver_not_ready_reg
                           & (func_sel_reg == iet_pkg::FUNC_OPEN_DRAIN);

   // low count byte
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         count_low_byte_reg <= iet_pkg::COUNT_LOW_RST;
      end else if (wr_low) begin
         count_low_byte_reg <= DAT_I[7:0];
      end
   end

   // counter bit eight, kept for read-back; a load takes it from the write data
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         count_bit_eight_reg <= 1'b0;
      end else if (wr_ctl) begin
         count_bit_eight_reg <= wr_bit8;
      end
   end

   // run enable; a cleared run freezes the count in place
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         run_enable_reg <= 1'b0;
      end else if (wr_ctl) begin
         run_enable_reg <= wr_run;
      end
   end

   // pin function select
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         func_sel_reg <= iet_pkg::FUNC_RST;
      end else if (wr_ctl) begin
         func_sel_reg <= wr_func;
      end
   end

   // operation end flag: the zero tick wins over a load, and a
   // load clears it only when no end tick lands in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         operation_end_flag_reg <= iet_pkg::END_RST;
      end else if (end_tick) begin
         operation_end_flag_reg <= 1'b1;
      end else if (load_ctl) begin
         operation_end_flag_reg <= 1'b0;
      end
   end

   // prescaler restarts with each load or start so the first step is full
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         presc_reg <= '0;
      end else if (load_ctl | run_rise | ~counting) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   // nine-bit down counter
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         counter_reg <= iet_pkg::COUNTER_RST;
      end else if (load_ctl) begin
         // a write that sets run over a cleared run also lands here,
         // which reloads the stored count
         counter_reg <= load_value;
      end else if (step) begin
         counter_reg <= counter_reg - iet_pkg::COUNTER_ONE;
      end
   end
   // a zero count still takes one tick before the end flag sets

   // stabilisation counter, restarted on every driver activation
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         stab_reg <= iet_pkg::STAB_LOAD;
      end else if (od_entry) begin
         stab_reg <= iet_pkg::STAB_LOAD;
      end else if (stab_reg != '0) begin
         stab_reg <= stab_reg - 1'b1;
      end
   end

   // not-ready flag; a new activation wins over the expiring delay
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         // reset leaves the open-drain function just turned on
         driver_not_ready_reg <= 1'b1;
      end else if (od_entry) begin
         driver_not_ready_reg <= 1'b1;
      end else if (stab_reg == '0) begin
         driver_not_ready_reg <= 1'b0;
      end
   end

   // halt edge detect
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         halt_prev_reg <= 1'b0;
      end else begin
         halt_prev_reg <= HALT_ACTIVE;
      end
   end

   // control read image; bits two to four stay zero
   always_comb begin
      ctl_rd                        = 8'h00;
      ctl_rd[iet_pkg::CTL_BIT8_POS] = count_bit_eight_reg;
      ctl_rd[iet_pkg::CTL_RUN_POS]  = run_enable_reg;
      ctl_rd[iet_pkg::CTL_NRDY_POS] = driver_not_ready;
      ctl_rd[iet_pkg::CTL_FUNC_POS] = func_sel_reg;
      ctl_rd[iet_pkg::CTL_END_POS]  = operation_end_flag_reg;
   end

   // status read image: live gate, zero-end and the counter itself
   always_comb begin
      sts_rd = iet_pkg::DATA_ZERO;
      sts_rd[iet_pkg::STS_GATE_POS] = counting;
      sts_rd[iet_pkg::STS_ZERO_POS] = counter_zero & ~counting;
      sts_rd[iet_pkg::STS_CNT_POS +: iet_pkg::CNT_W] = counter_reg;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_next = iet_pkg::DATA_ZERO;
      case (ADR_I)
         iet_pkg::ADDR_COUNT_LOW: begin
            rd_next[7:0] = count_low_byte_reg;
         end
         iet_pkg::ADDR_CONTROL: begin
            rd_next[7:0] = ctl_rd;
         end
         iet_pkg::ADDR_STATUS: begin
            rd_next = sts_rd;
         end
         default: begin
            rd_next = iet_pkg::DATA_ZERO;
         end
      endcase
   end

   // acknowledge: one cycle per taken request
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= bus_req;
      end
   end

   // read data holds until the next read
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         DAT_O <= iet_pkg::DATA_ZERO;
      end else if (rd_req) begin
         DAT_O <= rd_next;
      end
   end

   // timer output, one cycle behind the counting state
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TIMER_GATE <= 1'b0;
      end else begin
         TIMER_GATE <= counting;
      end
   end

   // end detector holds while zero and stopped
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TIMER_END <= 1'b0;
      end else begin
         TIMER_END <= counter_zero & ~counting;
      end
   end

   // neighbour carrier generator restarts in its low phase
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         CARRIER_RESTART <= 1'b0;
      end else begin
         CARRIER_RESTART <= run_rise | (load_ctl & wr_run);
      end
   end

   // pin level: carrier gated by the timer, or plain timer when disabled
   assign gated_signal = CARRIER_DISABLE ? counting : (counting & CARRIER_IN);

   // push-pull drives the level; open-drain never drives high
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         EMIT_O <= 1'b0;
      end else if (func_sel_reg == iet_pkg::FUNC_PUSH_PULL) begin
         EMIT_O <= gated_signal;
      end else begin
         EMIT_O <= 1'b0;
      end
   end

   // open-drain sinks while the signal is high and floats otherwise,
   // so an idle pin never pulls the emitter on
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         EMIT_OE <= 1'b0;
      end else if (func_sel_reg == iet_pkg::FUNC_PUSH_PULL) begin
         EMIT_OE <= 1'b1;
      end else begin
         EMIT_OE <= gated_signal;
      end
   end

endmodule // iet_envelope_timer

// ==== verification/iet_emitter_model.sv ====
// emitter model on the carrier pin: the led sinks while the pin is low.
// assumes an open-drain line with a pull-up, sampled on clk.
`timescale 1ns/1ps
module iet_emitter_model (
   input  wire logic        clk,
   input  wire logic        emit_o,
   input  wire logic        emit_oe,
   output logic      [31:0] low_count
);
   // a released pin is pulled high, never left at its last value
   wire pin = emit_oe ? emit_o : 1'b1;
   initial low_count = 32'h0000_0000;
   always @(posedge clk) if (pin === 1'b0) low_count <= low_count + 32'h0000_0001;
endmodule // iet_emitter_model

// ==== verification/iet_envelope_timer_monitor.sv ====
// port checker for the envelope timer: pin drive, gate start, end signal.
// assumes a bind onto the timer top module; one clock, sync reset.
`timescale 1ns/1ps
module iet_envelope_timer_monitor (
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic        STB_I,
   input wire logic        WE_I,
   input wire logic [7:0]  ADR_I,
   input wire logic [31:0] DAT_O,
   input wire logic        ACK_O,
   input wire logic        CARRIER_RESTART,
   input wire logic        TIMER_GATE,
   input wire logic        TIMER_END,
   input wire logic        EMIT_O,
   input wire logic        EMIT_OE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   gate_cause_a: assert property ($rose(TIMER_GATE) |-> $past(ACK_O) || $past(ACK_O, 2)
      || $past(ACK_O, 3)) else $error("gate rose without a write");
   end_holds_a: assert property ((TIMER_END && !STB_I) [*4] |=> TIMER_END)
      else $error("end signal dropped while idle");
   od_sink_a: assert property (EMIT_O |-> EMIT_OE) else $error("pin level undriven");
   idle_low_a: assert property (!TIMER_GATE && !$past(TIMER_GATE) |-> !EMIT_O)
      else $error("pin high while idle");
   restart_gate_a: assert property (CARRIER_RESTART |-> ##[0:3] TIMER_GATE)
      else $error("restart without gate");
   restart_once_a: assert property (CARRIER_RESTART |=> !CARRIER_RESTART)
      else $error("restart held");
   reset_idle_a: assert property ($fell(RST) |->
      !EMIT_OE ##1 (TIMER_END && !TIMER_GATE)) else $error("busy after reset");
   ctl_zero_a: assert property (ACK_O && !WE_I && ADR_I == iet_pkg::ADDR_CONTROL
      |-> DAT_O[4:2] == 3'h0 && !(DAT_O[6] && DAT_O[5])) else $error("control bits set");
   cover property ($fell(TIMER_GATE) ##[1:4] TIMER_END);
   cover property (CARRIER_RESTART);
   cover property (ACK_O && DAT_O[5]);
endmodule // iet_envelope_timer_monitor

// ==== verification/iet_envelope_timer_tb.sv ====
// self-checking bench for the envelope timer over classic wishbone.
// assumes package, design, emitter model and checker compiled first.
`timescale 1ns/1ps
module iet_envelope_timer_tb;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        car = 1'b0, cdis = 1'b1, halt = 1'b0, ack, rsr, gate, tend, eo, eoe;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000, glen = 32'h0000_0000, len = 32'h0000_0000;
   logic [31:0] dout, q, sink, base;
   int          err_count = 0, comparisons = 0;
   iet_envelope_timer DUT (.REF_CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dout), .ACK_O(ack), .CARRIER_IN(car),
      .CARRIER_DISABLE(cdis), .HALT_ACTIVE(halt), .CARRIER_RESTART(rsr), .TIMER_GATE(gate),
      .TIMER_END(tend), .EMIT_O(eo), .EMIT_OE(eoe));
   iet_emitter_model EMU (.clk(clk), .emit_o(eo), .emit_oe(eoe), .low_count(sink));
   initial forever #2 clk = ~clk;
   // carrier toggles every clock, so an even burst sinks exactly half
   always @(posedge clk) car <= ~car;
   always @(posedge clk) glen <= (gate === 1'b1) ? glen + 32'h0000_0001 : 32'h0000_0000;
   always @(posedge clk) if (gate !== 1'b1 && glen != 32'h0000_0000) len <= glen;
   task automatic close_out;
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // request held until ack is sampled high, then released
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h00_0000, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = dout;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, {24'h00_0000, e});
   endtask
   // waits on the gate first: the last run's end signal outlasts the load by a cycle
   task automatic run_to_end(input logic [31:0] e);
      do @(posedge clk); while (gate !== 1'b1);
      do @(posedge clk); while (tend !== 1'b1);
      repeat (3) @(posedge clk);
      chk(len, e);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(8'h04, 8'hA0);
      chk(32'(eoe), 32'h0000_0000);
      do wb(1'b0, 8'h04, 8'h00); while (q[5] !== 1'b0);
      rd(8'h04, 8'h80);
      wb(1'b1, 8'h00, 8'h02);
      wb(1'b1, 8'h04, 8'h1C);
      rd(8'h04, 8'h00);
      base = sink;
      wb(1'b1, 8'h04, 8'h02);
      run_to_end(32'h0000_00C0);
      chk(sink - base, 32'h0000_00C0);
      rd(8'h04, 8'h82);
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b1, 8'h04, 8'h02);
      run_to_end(32'h0000_0040);
      wb(1'b1, 8'h00, 8'h05);
      wb(1'b1, 8'h04, 8'h00);
      wb(1'b1, 8'h04, 8'h02);
      repeat (100) @(posedge clk);
      wb(1'b1, 8'h04, 8'h00);
      repeat (4) @(posedge clk);
      chk(32'({gate, tend}), 32'h0000_0000);
      wb(1'b0, 8'h08, 8'h00);
      chk(q, 32'h0004_0000);
      wb(1'b1, 8'h04, 8'h02);
      run_to_end(32'h0000_0180);
      wb(1'b1, 8'h04, 8'h40);
      rd(8'h04, 8'h40);
      chk(32'({eoe, eo}), 32'h0000_0002);
      wb(1'b1, 8'h04, 8'h00);
      rd(8'h04, 8'h20);
      do wb(1'b0, 8'h04, 8'h00); while (q[5] !== 1'b0);
      halt <= 1'b1;
      repeat (3) @(posedge clk);
      halt <= 1'b0;
      rd(8'h04, 8'h20);
      do wb(1'b0, 8'h04, 8'h00); while (q[5] !== 1'b0);
      wb(1'b1, 8'h04, 8'h01);
      rd(8'h04, 8'h01);
      wb(1'b1, 8'h0C, 8'hFF);
      rd(8'h0C, 8'h00);
      cdis <= 1'b0;
      base = sink;
      wb(1'b1, 8'h00, 8'h00);
      wb(1'b1, 8'h04, 8'h02);
      run_to_end(32'h0000_0040);
      chk(sink - base, 32'h0000_0020);
      rd(8'h08, 8'h02);
      close_out();
   end
   initial begin
      #40000;
      err_count++;
      close_out();
   end
endmodule // iet_envelope_timer_tb
bind iet_envelope_timer iet_envelope_timer_monitor MON (.REF_CLK(REF_CLK), .RST(RST),
   .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
   .CARRIER_RESTART(CARRIER_RESTART), .TIMER_GATE(TIMER_GATE), .TIMER_END(TIMER_END),
   .EMIT_O(EMIT_O), .EMIT_OE(EMIT_OE));
